/* src/gip_chain.sv */
// Purpose: frame-based gray image preprocess chain with input FIFO
// Assumes: frames of IMG_N pixels in raster order, one clock
// Notes: config is caught with the first pixel of each frame
// Notes on behaviour
// - one arrangement plus five selectable filter slots
// - slots run in order, each on previous output
// - output stream is always the processed frame
// - arrangement: rotate 180, mirror, or flip
// - gauss: 3x3 weighted 1-2-1 smoothing
// - erosion: window minimum
// - dilation: window maximum
// - median: window median
// - mean: window average
// - range: window maximum minus minimum
// - std deviation of window values
// - sobel gradient magnitude, clipped to 255
// - multiply by 2/4/8/16, clip at 255
// - slot set off passes image unchanged
`timescale 1ns/1ps

module gip_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } gip_fifo_st_t;

  gip_fifo_st_t q;
  gip_fifo_st_t d;
  logic [W-1:0] mem [DEPTH];
  logic wr;
  logic rd;

  // honest full and empty from the fill count
  assign in_ready_o = q.cnt != (PW+1)'(DEPTH);
  assign out_valid_o = q.cnt != '0;
  assign out_data_o = mem[q.rp];
  assign wr = in_valid_i & in_ready_o;
  assign rd = out_valid_o & out_ready_i;

  // pointer and count update
  always_comb
  begin
    d = q;
    if (wr)
      d.wp = q.wp + 1'b1;
    if (rd)
      d.rp = q.rp + 1'b1;
    d.cnt = q.cnt + (PW+1)'(wr) - (PW+1)'(rd);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      q <= '0;
    else
      q <= d;
    if (wr)
      mem[q.wp] <= in_data_i;
  end

endmodule : gip_fifo

module gip_chain (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [7:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire gip_pkg::gip_arr_t arr_sel_i,
  input wire gip_pkg::gip_cfg_t cfg_i,
  output gip_pkg::gip_pix_t out_pix_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  import gip_pkg::*;

  typedef struct packed {
    gip_st_t st;
    gip_arr_t arr;
    gip_cfg_t cfg;
    logic [2:0] slot;
    logic bank;
    logic [AW-1:0] idx;
    logic [3:0] k;
    logic [KWIN-1:0][7:0] win;
    gip_pix_t opix;
  } gip_core_st_t;

  gip_core_st_t q;
  gip_core_st_t d;
  logic [7:0] fbuf [2][IMG_N]; // ping-pong frame banks
  logic we;
  logic wb;
  logic [AW-1:0] wa;
  logic [7:0] wdat;
  logic [7:0] f_data;
  logic f_valid;
  logic f_ready;
  logic wfire;
  gip_slot_t cur;
  gip_arr_t asel;
  logic [7:0] res;
  logic [7:0] mn;
  logic [7:0] mx;
  logic [11:0] sum;
  logic [11:0] gsum;
  logic [19:0] sq;
  logic [11:0] gx;
  logic [11:0] gy;
  logic [11:0] mag;
  logic [11:0] prod;
  logic [23:0] var9;

  // arrangement as a write-address remap
  function automatic logic [AW-1:0] arr_addr(
    input logic [AW-1:0] a,
    input gip_arr_t s
  );
    logic [AW-1:0] r;
    r = a;
    unique case (s)
      GIP_AR_NONE: r = a;
      GIP_AR_ROT: r = ~a;
      GIP_AR_MIRROR: r = {~a[AW-1:XW], a[XW-1:0]};
      GIP_AR_FLIP: r = {a[AW-1:XW], ~a[XW-1:0]};
    endcase
    return r;
  endfunction : arr_addr

  // neighbour address, clamped at the borders
  function automatic logic [AW-1:0] win_addr(
    input logic [AW-1:0] a,
    input logic [3:0] k
  );
    logic [XW-1:0] x;
    logic [AW-XW-1:0] y;
    logic [1:0] dx;
    logic [1:0] dy;
    x = a[XW-1:0];
    y = a[AW-1:XW];
    dx = 2'(k % 4'd3);
    dy = 2'(k / 4'd3);
    if (dx == 2'd0 && x != '0)
      x = x - 1'b1;
    if (dx == 2'd2 && x != '1)
      x = x + 1'b1;
    if (dy == 2'd0 && y != '0)
      y = y - 1'b1;
    if (dy == 2'd2 && y != '1)
      y = y + 1'b1;
    return {y, x};
  endfunction : win_addr

  // median by rank counting
  function automatic logic [7:0] median9(input logic [KWIN-1:0][7:0] w);
    logic [3:0] lt;
    logic [3:0] le;
    logic [7:0] m;
    m = w[0];
    for (int i = 0; i < KWIN; i++)
    begin
      lt = '0;
      le = '0;
      for (int j = 0; j < KWIN; j++)
      begin
        lt = lt + 4'(w[j] < w[i]);
        le = le + 4'(w[j] <= w[i]);
      end
      if (lt <= 4'd4 && le >= 4'd5)
        m = w[i];
    end
    return m;
  endfunction : median9

  // bitwise integer square root
  function automatic logic [11:0] isqrt(input logic [23:0] v);
    logic [11:0] r;
    logic [11:0] t;
    r = '0;
    for (int b = 11; b >= 0; b--)
    begin
      t = r | (12'h1 << b);
      if (24'(t) * 24'(t) <= v)
        r = t;
    end
    return r;
  endfunction : isqrt

  gip_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .in_data_i(in_data_i),
    .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o),
    .out_data_o(f_data),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready)
  );

  // fifo drains only while a frame is loaded
  assign f_ready = q.st == GIP_ST_LOAD;
  assign out_valid_o = q.st == GIP_ST_OUT;
  assign out_pix_o = q.opix;
  assign wfire = we && q.st == GIP_ST_PROC;

  // window statistics and filter result
  always_comb
  begin
    sum = '0;
    gsum = '0;
    sq = '0;
    mn = PIX_MAX;
    mx = '0;
    for (int i = 0; i < KWIN; i++)
    begin
      sum = sum + 12'(q.win[i]);
      sq = sq + 20'(q.win[i]) * 20'(q.win[i]);
      gsum = gsum + (12'(q.win[i]) << ((i == KCTR) ? 2 : (i % 2)));
      if (q.win[i] < mn)
        mn = q.win[i];
      if (q.win[i] > mx)
        mx = q.win[i];
    end
    gx = 12'(q.win[2]) + {3'h0, q.win[5], 1'b0} + 12'(q.win[8])
       - 12'(q.win[0]) - {3'h0, q.win[3], 1'b0} - 12'(q.win[6]);
    gy = 12'(q.win[6]) + {3'h0, q.win[7], 1'b0} + 12'(q.win[8])
       - 12'(q.win[0]) - {3'h0, q.win[1], 1'b0} - 12'(q.win[2]);
    mag = (gx[11] ? -gx : gx) + (gy[11] ? -gy : gy);
    prod = 12'(q.win[KCTR]) << (3'(cur.mult) + 3'd1);
    var9 = 24'(sq) * 24'd9 - 24'(sum) * 24'(sum);
    unique case (cur.ftype)
      GIP_F_GAUSS: res = 8'((gsum + 12'd8) >> 4);
      GIP_F_ERODE: res = mn;
      GIP_F_DILATE: res = mx;
      GIP_F_MEDIAN: res = median9(q.win);
      GIP_F_MEAN: res = 8'(sum / 12'd9);
      GIP_F_RANGE: res = mx - mn;
      GIP_F_STDDEV: res = 8'(isqrt(var9) / 12'd9);
      GIP_F_SOBEL: res = (mag > 12'd255) ? PIX_MAX : mag[7:0];
      GIP_F_MULT: res = (prod > 12'd255) ? PIX_MAX : prod[7:0];
      GIP_F_INVERT: res = PIX_MAX - q.win[KCTR];
      default: res = q.win[KCTR]; // unused codes pass
    endcase
  end

  // sequencer: load, five slot passes, stream out
  always_comb
  begin
    d = q;
    we = 1'b0;
    wb = 1'b0;
    wa = '0;
    wdat = '0;
    cur = '0;
    asel = (q.idx == '0) ? arr_sel_i : q.arr;
    if (q.slot < 3'(NSLOT))
      cur = q.cfg[q.slot];
    unique case (q.st)
      GIP_ST_LOAD:
      begin
        if (f_valid)
        begin
          if (q.idx == '0)
          begin
            d.arr = arr_sel_i;
            d.cfg = cfg_i;
          end
          we = 1'b1;
          wa = arr_addr(q.idx, asel);
          wdat = f_data;
          d.idx = q.idx + 1'b1;
          if (q.idx == AW'(IMG_N-1))
          begin
            d.st = GIP_ST_PROC;
            d.slot = '0;
            d.bank = 1'b0;
            d.k = '0;
          end
        end
      end
      GIP_ST_PROC:
      begin
        if (q.slot == 3'(NSLOT))
        begin
          d.st = GIP_ST_OUT;
          d.idx = '0;
          d.opix.data = fbuf[q.bank][0];
          d.opix.last = IMG_N == 1;
        end
        else if (!cur.ksize_on)
          d.slot = q.slot + 1'b1;
        else if (q.k != 4'(KWIN))
        begin
          d.win[q.k] = fbuf[q.bank][win_addr(q.idx, q.k)];
          d.k = q.k + 1'b1;
        end
        else
        begin
          we = 1'b1;
          wb = ~q.bank;
          wa = q.idx;
          wdat = res;
          d.k = '0;
          d.idx = q.idx + 1'b1;
          if (q.idx == AW'(IMG_N-1))
          begin
            d.slot = q.slot + 1'b1;
            d.bank = ~q.bank;
          end
        end
      end
      GIP_ST_OUT:
      begin
        if (out_ready_i)
        begin
          d.idx = q.idx + 1'b1;
          d.opix.data = fbuf[q.bank][AW'(q.idx + 1'b1)];
          d.opix.last = q.idx == AW'(IMG_N-2);
          if (q.idx == AW'(IMG_N-1))
            d.st = GIP_ST_LOAD;
        end
      end
      default: d.st = GIP_ST_LOAD;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      q <= '0;
    else
      q <= d;
    if (we)
      fbuf[wb][wa] <= wdat;
  end

  // off slot is skipped in one cycle, no write
  property p_off_skip;
    @(posedge clk_sys_i) disable iff (srst_i)
    q.st == GIP_ST_PROC && q.slot < 3'(NSLOT) && !cur.ksize_on
    |=> q.slot == $past(q.slot) + 3'd1 && !$past(we);
  endproperty
  a_off_skip: assert property (p_off_skip)
    else $error("off slot not skipped");

  // last pixel of a pass moves to next slot and bank
  property p_order;
    @(posedge clk_sys_i) disable iff (srst_i)
    wfire && q.idx == AW'(IMG_N-1)
    |=> q.slot == $past(q.slot) + 3'd1 && q.bank != $past(q.bank);
  endproperty
  a_order: assert property (p_order)
    else $error("slot order broken");

  // ten cycles per filtered pixel
  property p_pace;
    @(posedge clk_sys_i) disable iff (srst_i)
    wfire && q.idx != AW'(IMG_N-1)
    |=> !wfire [*8] ##1 !wfire ##1 wfire;
  endproperty
  a_pace: assert property (p_pace)
    else $error("pixel pace wrong");

  property p_erode;
    @(posedge clk_sys_i) disable iff (srst_i)
    wfire && cur.ftype == GIP_F_ERODE |-> wdat <= q.win[0]
      && wdat <= q.win[KCTR] && wdat <= q.win[8];
  endproperty
  a_erode: assert property (p_erode)
    else $error("erosion above window value");

  property p_dilate;
    @(posedge clk_sys_i) disable iff (srst_i)
    wfire && cur.ftype == GIP_F_DILATE |-> wdat >= q.win[0]
      && wdat >= q.win[KCTR] && wdat >= q.win[8];
  endproperty
  a_dilate: assert property (p_dilate)
    else $error("dilation below window value");

  property p_mult;
    @(posedge clk_sys_i) disable iff (srst_i)
    wfire && cur.ftype == GIP_F_MULT && q.win[KCTR][7]
    |-> wdat == PIX_MAX;
  endproperty
  a_mult: assert property (p_mult)
    else $error("multiply not clipped");

  property p_inv;
    @(posedge clk_sys_i) disable iff (srst_i)
    wfire && cur.ftype == GIP_F_INVERT |-> wdat + q.win[KCTR] == PIX_MAX;
  endproperty
  a_inv: assert property (p_inv)
    else $error("inversion wrong");

  property p_rot;
    @(posedge clk_sys_i) disable iff (srst_i)
    q.st == GIP_ST_LOAD && f_valid && q.idx != '0 && q.arr == GIP_AR_ROT
    |-> wa == AW'(IMG_N-1) - q.idx;
  endproperty
  a_rot: assert property (p_rot)
    else $error("rotation address wrong");

  property p_out;
    @(posedge clk_sys_i) disable iff (srst_i)
    out_valid_o |-> q.slot == 3'(NSLOT);
  endproperty
  a_out: assert property (p_out)
    else $error("output before all slots");

endmodule : gip_chain

/* common/gip_pkg.sv */
// Purpose: shared constants and types of the gray image preprocess chain
// Assumes: square power-of-two image, 8-bit unsigned gray pixels
// Notes: one frame is held whole, so the image is kept small
package gip_pkg;

  localparam int IMG_W = 16;
  localparam int IMG_H = 16;
  localparam int IMG_N = IMG_W * IMG_H;
  localparam int XW = 4; // log2 of IMG_W
  localparam int AW = 8; // log2 of IMG_N
  localparam int NSLOT = 5;
  localparam int KWIN = 9; // 3x3 window
  localparam int KCTR = 4; // window centre
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] PIX_MAX = 8'hff;

  // filter kinds of one slot
  typedef enum logic [3:0] {
    GIP_F_GAUSS = 4'h0,
    GIP_F_ERODE = 4'h1,
    GIP_F_DILATE = 4'h2,
    GIP_F_MEDIAN = 4'h3,
    GIP_F_MEAN = 4'h4,
    GIP_F_RANGE = 4'h5,
    GIP_F_STDDEV = 4'h6,
    GIP_F_SOBEL = 4'h7,
    GIP_F_MULT = 4'h8,
    GIP_F_INVERT = 4'h9
  } gip_filt_t;

  // arrangement choices
  typedef enum logic [1:0] {
    GIP_AR_NONE = 2'h0,
    GIP_AR_ROT = 2'h1,
    GIP_AR_MIRROR = 2'h2,
    GIP_AR_FLIP = 2'h3
  } gip_arr_t;

  typedef enum logic [1:0] {
    GIP_ST_LOAD = 2'h0,
    GIP_ST_PROC = 2'h1,
    GIP_ST_OUT = 2'h2
  } gip_st_t;

  // ksize_on: 0 off, 1 3x3; mult: factor 2 << mult
  typedef struct packed {
    gip_filt_t ftype;
    logic ksize_on;
    logic [1:0] mult;
  } gip_slot_t;

  typedef gip_slot_t [NSLOT-1:0] gip_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } gip_pix_t;

endpackage : gip_pkg

/* bench/gip_far_end.sv */
// Purpose: far-end model, pixel source and result sink
// Assumes: transfers taken at rising edge, driven at falling edge
// Notes: idle data shows the inverse of its last value
`timescale 1ns/1ps
module gip_far_end (
  input wire logic clk_sys_i,
  input wire logic pix_ready_i,
  input wire gip_pkg::gip_pix_t res_pix_i,
  input wire logic res_valid_i,
  output logic [7:0] pix_data_o,
  output logic pix_valid_o,
  output logic sink_ready_o
);
  import gip_pkg::*;
  logic [7:0] got[IMG_N];
  logic lst[IMG_N];
  int stalls;
  int first_k;

  // idle at time zero
  initial
  begin
    pix_data_o = 8'h00;
    pix_valid_o = 1'b0;
    sink_ready_o = 1'b0;
  end

  // offer n pixels, held until taken; slow mode leaves gaps
  task automatic send(input int img[IMG_N], input int n, input bit slow,
                      output bit ok);
    int w;
    ok = 1'b1;
    stalls = 0;
    first_k = -1;
    for (int k = 0; k < n && ok; k++)
    begin
      @(negedge clk_sys_i);
      if (slow && k % 3 == 2)
      begin
        pix_valid_o = 1'b0;
        pix_data_o = ~pix_data_o;
        @(negedge clk_sys_i);
      end
      pix_valid_o = 1'b1;
      pix_data_o = img[k][7:0];
      w = 0;
      while (!pix_ready_i && ok)
      begin
        if (first_k < 0)
          first_k = k;
        stalls++;
        w++;
        ok = w < 40000;
        @(negedge clk_sys_i);
      end
    end
    @(negedge clk_sys_i);
    pix_valid_o = 1'b0;
    pix_data_o = ~pix_data_o;
  endtask : send

  // take one frame; slow mode refuses every other cycle
  task automatic recv(input bit slow, output bit ok);
    int k;
    int w;
    k = 0;
    w = 0;
    ok = 1'b1;
    while (k < IMG_N && ok)
    begin
      @(negedge clk_sys_i);
      sink_ready_o = !(slow && w[0]);
      if (res_valid_i === 1'b1 && sink_ready_o)
      begin
        got[k] = res_pix_i.data;
        lst[k] = res_pix_i.last;
        k++;
      end
      w++;
      ok = w < 60000;
    end
    @(negedge clk_sys_i);
    sink_ready_o = 1'b0;
  endtask : recv
endmodule : gip_far_end

/* bench/gip_chain_tb.sv */
// Purpose: self-checking bench of the gray image preprocess chain
// Assumes: 16x16 frames, 100 MHz clock, inputs moved at falling edge
// Notes: expected frames come from a bench-side pixel model
`timescale 1ns/1ps
module gip_chain_tb;
  import gip_pkg::*;
  typedef struct packed {
    gip_arr_t arr;
    gip_cfg_t cfg;
  } gip_row_t;
  localparam gip_slot_t OF = '{GIP_F_INVERT, 1'b0, 2'h0};
  logic clk_sys_i;
  logic srst_i;
  logic [7:0] in_data;
  logic in_valid;
  logic in_ready;
  gip_arr_t arr_sel;
  gip_cfg_t cfg;
  gip_pix_t out_pix;
  logic out_valid;
  logic out_ready;
  int num_errors;
  int tests_run;
  int src[IMG_N];
  int src_a[IMG_N];
  int cur[IMG_N];
  int nxt[IMG_N];
  int exp_a[IMG_N];
  gip_row_t rows[8];
  bit ok[4];

  gip_chain u_dut (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .in_data_i(in_data),
    .in_valid_i(in_valid),
    .in_ready_o(in_ready),
    .arr_sel_i(arr_sel),
    .cfg_i(cfg),
    .out_pix_o(out_pix),
    .out_valid_o(out_valid),
    .out_ready_i(out_ready)
  );

  gip_far_end u_far (
    .clk_sys_i(clk_sys_i),
    .pix_ready_i(in_ready),
    .res_pix_i(out_pix),
    .res_valid_i(out_valid),
    .pix_data_o(in_data),
    .pix_valid_o(in_valid),
    .sink_ready_o(out_ready)
  );

  // 100 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  function automatic gip_slot_t sl(gip_filt_t f, logic [1:0] m = 2'h0);
    return '{f, 1'b1, m};
  endfunction : sl

  // clamped read, so borders repeat the edge pixel
  function automatic int px(int x, int y);
    x = x < 0 ? 0 : (x > IMG_W - 1 ? IMG_W - 1 : x);
    y = y < 0 ? 0 : (y > IMG_H - 1 ? IMG_H - 1 : y);
    return cur[y * IMG_W + x];
  endfunction : px

  task automatic chk(input bit good, input string what);
    tests_run++;
    if (!good)
    begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk

  task automatic give_verdict;
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // a wait that ran out ends the run
  task automatic fin_ok(input bit good);
    if (!good)
    begin
      chk(1'b0, "wait ran out");
      give_verdict();
    end
  endtask : fin_ok

  task automatic mk_src(input int seed);
    for (int k = 0; k < IMG_N; k++)
      src[k] = (k * seed + (k >> 4) * 29) & 255;
  endtask : mk_src

  // one slot of the pixel model, off slots pass the image
  task automatic run_slot(input gip_slot_t s);
    int w[9];
    int sum, sq, gs, gx, gy, dx, dy, v, r, t, c;
    if (!s.ksize_on)
      return;
    for (int k = 0; k < IMG_N; k++)
    begin
      {sum, sq, gs, gx, gy} = '0;
      c = cur[k];
      for (int j = 0; j < 9; j++)
      begin
        dx = j % 3 - 1;
        dy = j / 3 - 1;
        w[j] = px(k % IMG_W + dx, k / IMG_W + dy);
        sum += w[j];
        sq += w[j] * w[j];
        gs += w[j] * (2 - dx * dx) * (2 - dy * dy);
        gx += w[j] * dx * (2 - dy * dy);
        gy += w[j] * dy * (2 - dx * dx);
      end
      w.sort();
      case (s.ftype)
        GIP_F_GAUSS: v = (gs + 8) >> 4;
        GIP_F_ERODE: v = w[0];
        GIP_F_DILATE: v = w[8];
        GIP_F_MEDIAN: v = w[4];
        GIP_F_MEAN: v = sum / 9;
        GIP_F_RANGE: v = w[8] - w[0];
        GIP_F_STDDEV:
        begin
          t = 9 * sq - sum * sum;
          r = 0;
          while ((r + 1) * (r + 1) <= t)
            r++;
          v = r / 9;
        end
        GIP_F_SOBEL: v = (gx < 0 ? -gx : gx) + (gy < 0 ? -gy : gy);
        GIP_F_MULT: v = c * (2 << s.mult);
        GIP_F_INVERT: v = 255 - c;
        default: v = c;
      endcase
      nxt[k] = v > 255 ? 255 : v;
    end
    cur = nxt;
  endtask : run_slot

  // arrangement first, then the five slots in order
  task automatic model(input gip_row_t rw);
    int x, y;
    for (int k = 0; k < IMG_N; k++)
    begin
      x = k % IMG_W;
      y = k / IMG_W;
      case (rw.arr)
        GIP_AR_ROT: cur[k] = src[IMG_N - 1 - k];
        GIP_AR_MIRROR: cur[k] = src[(IMG_H - 1 - y) * IMG_W + x];
        GIP_AR_FLIP: cur[k] = src[y * IMG_W + IMG_W - 1 - x];
        default: cur[k] = src[k];
      endcase
    end
    for (int i = 0; i < NSLOT; i++)
      run_slot(rw.cfg[i]);
  endtask : model

  task automatic cmp_frame(input int e[IMG_N]);
    for (int k = 0; k < IMG_N; k++)
    begin
      tests_run++;
      if (u_far.got[k] !== e[k][7:0] || u_far.lst[k] !== (k == IMG_N - 1))
      begin
        num_errors++;
        $display("mismatch at %0t: pixel %0d is %h, want %h", $time, k,
                 u_far.got[k], e[k][7:0]);
      end
    end
  endtask : cmp_frame

  // send a frame, collect the result, compare
  task automatic one_frame(input gip_row_t rw, input int seed,
                           input bit [1:0] slow);
    mk_src(seed);
    model(rw);
    @(negedge clk_sys_i);
    arr_sel = rw.arr;
    cfg = rw.cfg;
    fork
      u_far.send(src, IMG_N, slow[0], ok[0]);
      u_far.recv(slow[1], ok[1]);
    join
    fin_ok(ok[0] && ok[1]);
    cmp_frame(cur);
  endtask : one_frame

  // main sequence
  initial
  begin
    srst_i = 1'b1;
    arr_sel = GIP_AR_NONE;
    cfg = '0;
    num_errors = 0;
    tests_run = 0;
    rows[0] = '{GIP_AR_NONE, {OF, OF, OF, OF, OF}};
    rows[1] = '{GIP_AR_ROT, {sl(GIP_F_MULT), OF, OF, OF,
                sl(GIP_F_INVERT)}};
    rows[2] = '{GIP_AR_MIRROR, {OF, OF, OF, OF, sl(GIP_F_ERODE)}};
    rows[3] = '{GIP_AR_FLIP, {OF, OF, OF, sl(GIP_F_MULT, 2'h1),
                sl(GIP_F_DILATE)}};
    rows[4] = '{GIP_AR_NONE, {OF, OF, OF, sl(GIP_F_MEAN),
                sl(GIP_F_MEDIAN)}};
    rows[5] = '{GIP_AR_NONE, {OF, OF, sl(GIP_F_MULT, 2'h2),
                sl(GIP_F_STDDEV), sl(GIP_F_RANGE)}};
    rows[6] = '{GIP_AR_NONE, {OF, OF, OF, sl(GIP_F_SOBEL),
                sl(GIP_F_GAUSS)}};
    rows[7] = '{GIP_AR_ROT, {sl(GIP_F_INVERT), sl(GIP_F_MULT, 2'h3),
                sl(GIP_F_DILATE), sl(GIP_F_ERODE),
                sl(GIP_F_GAUSS)}};
    repeat (10) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    srst_i = 1'b0;
    chk(in_ready === 1'b1 && out_valid === 1'b0 && out_pix === '0, "reset");
    for (int r = 0; r < 8; r++)
      one_frame(rows[r], 2 * r + 5, r[1:0]);
    // second frame waits in the fifo while the first is filtered
    mk_src(77);
    src_a = src;
    model(rows[2]);
    exp_a = cur;
    mk_src(91);
    model(rows[2]);
    // both queued frames run under the mirror and erosion setting
    @(negedge clk_sys_i);
    arr_sel = rows[2].arr;
    cfg = rows[2].cfg;
    fork
      begin
        u_far.send(src_a, IMG_N, 1'b0, ok[0]);
        u_far.send(src, IMG_N, 1'b0, ok[1]);
      end
      begin
        u_far.recv(1'b1, ok[2]);
        cmp_frame(exp_a);
        u_far.recv(1'b0, ok[3]);
      end
    join
    fin_ok(ok[0] && ok[1] && ok[2] && ok[3]);
    cmp_frame(cur);
    chk(u_far.stalls > 0 && u_far.first_k >= FIFO_DEPTH, "fifo refusal");
    // reset in mid-frame drops what was taken
    mk_src(33);
    u_far.send(src, 100, 1'b0, ok[0]);
    srst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    srst_i = 1'b0;
    chk(in_ready === 1'b1 && out_valid === 1'b0 && out_pix === '0, "reset");
    one_frame(rows[1], 13, 2'h3);
    give_verdict();
  end
endmodule : gip_chain_tb
